/* hw/tcsrc_cc_decode.sv */
// CC termination pair to attach state, orientation and VCONN side
`timescale 1ns/10ps
module tcsrc_cc_decode (
   // Terminations
   input  tcsrc_pkg::tcsrc_term_t  cc1Term,
   input  tcsrc_pkg::tcsrc_term_t  cc2Term,
   // Decoded target
   output tcsrc_pkg::tcsrc_state_t next_state,
   output logic                    next_flip,
   output tcsrc_pkg::tcsrc_vconn_t next_vconn
);
   always_comb begin
      next_state = tcsrc_pkg::ST_UNATTACHED;
      next_flip  = 1'b0;
      next_vconn = tcsrc_pkg::VCONN_OFF;
      if (cc1Term == tcsrc_pkg::TERM_RD && cc2Term == tcsrc_pkg::TERM_RD) begin
         next_state = tcsrc_pkg::ST_DEBUG_UNORIENTED;
      end else if (cc1Term == tcsrc_pkg::TERM_RA &&
                   cc2Term == tcsrc_pkg::TERM_RA) begin
         next_state = tcsrc_pkg::ST_AUDIO;
      end else if (cc1Term == tcsrc_pkg::TERM_RD) begin
         case (cc2Term)
            tcsrc_pkg::TERM_OPEN: next_state = tcsrc_pkg::ST_ATTACHED;
            tcsrc_pkg::TERM_RA: begin
               next_state = tcsrc_pkg::ST_ATTACHED;
               next_vconn = tcsrc_pkg::VCONN_CC2;
            end
            tcsrc_pkg::TERM_LOW: next_state = tcsrc_pkg::ST_DEBUG_ORIENTED;
            default: next_state = tcsrc_pkg::ST_UNATTACHED;
         endcase
      end else if (cc2Term == tcsrc_pkg::TERM_RD) begin
         next_flip = 1'b1;
         case (cc1Term)
            tcsrc_pkg::TERM_OPEN: next_state = tcsrc_pkg::ST_ATTACHED;
            tcsrc_pkg::TERM_RA: begin
               next_state = tcsrc_pkg::ST_ATTACHED;
               next_vconn = tcsrc_pkg::VCONN_CC1;
            end
            tcsrc_pkg::TERM_LOW: next_state = tcsrc_pkg::ST_DEBUG_ORIENTED;
            default: begin
               next_state = tcsrc_pkg::ST_UNATTACHED;
               next_flip  = 1'b0;
            end
         endcase
      end
   end
endmodule // tcsrc_cc_decode

/* hw/tcsrc_irq.sv */
// Sticky event status, enable mask and level interrupt
`timescale 1ns/10ps
module tcsrc_irq #(
   parameter int W = 3
) (
   // Clock and reset
   input  logic         clk_sys,
   input  logic         reset,
   // Events and software access
   input  logic [W-1:0] eventIn,
   input  logic         enableWr,
   input  logic         clearWr,
   input  logic [W-1:0] wrData,
   // State
   output logic [W-1:0] status,
   output logic [W-1:0] enable,
   output logic         irq
);
   logic [W-1:0] next_status;
   logic [W-1:0] next_enable;

   if (W < 1) begin : g_check
      $error("tcsrc_irq needs at least one event");
   end

   // Set wins over a clear in the same cycle
   always_comb begin
      next_status = (status & ~(clearWr ? wrData : '0)) | eventIn;
      next_enable = enableWr ? wrData : enable;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status <= '0;
         enable <= W'(tcsrc_pkg::IRQ_ENABLE_RESET);
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq    <= |(next_status & next_enable);
      end
   end

   a_sticky_set: assert property (@(posedge clk_sys) disable iff (reset)
      (eventIn != '0) |=> ((status & $past(eventIn)) == $past(eventIn)))
      else $error("event bit not latched");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
      irq == ((status & enable) != '0))
      else $error("interrupt level disagrees with status");
endmodule // tcsrc_irq

/* hw/tcsrc_pkg.sv */
// Shared constants, types and helpers of the source attach output block
package tcsrc_pkg;

   // Termination seen on one CC line; LOW is a resistance below Ra
   typedef enum logic [2:0] {
      TERM_OPEN, TERM_RA, TERM_RD, TERM_RP, TERM_LOW
   } tcsrc_term_t;

   typedef enum logic [2:0] {
      ST_UNATTACHED, ST_ATTACHED, ST_DEBUG_UNORIENTED,
      ST_DEBUG_ORIENTED, ST_AUDIO
   } tcsrc_state_t;

   typedef enum logic [1:0] {VCONN_OFF, VCONN_CC1, VCONN_CC2} tcsrc_vconn_t;

   // Register indices (word addresses on the bus)
   localparam logic [7:0] REG_ATTACH_STATUS = 8'h0e;
   localparam logic [7:0] REG_PORT_STATE    = 8'h11;
   localparam logic [7:0] REG_IRQ_STATUS    = 8'h12;
   localparam logic [7:0] REG_IRQ_ENABLE    = 8'h13;
   localparam logic [7:0] REG_IRQ_CLEAR     = 8'h14;
   localparam logic [7:0] REG_CONTROL       = 8'h15;
   localparam logic [7:0] REG_PIN_STATUS    = 8'h16;

   // Attach status codes
   localparam logic [7:0] CODE_NONE       = 8'h00;
   localparam logic [7:0] CODE_SINK       = 8'h2d;
   localparam logic [7:0] CODE_SINK_VCONN = 8'h2f;
   localparam logic [7:0] CODE_DEBUG      = 8'h6d;
   localparam logic [7:0] CODE_AUDIO      = 8'h81;

   // Port state codes
   localparam logic [7:0] PORT_UNATTACHED = 8'h00;
   localparam logic [7:0] PORT_ATTACHED   = 8'h01;
   localparam logic [7:0] PORT_DBG_UNOR   = 8'h02;
   localparam logic [7:0] PORT_DBG_OR     = 8'h03;
   localparam logic [7:0] PORT_AUDIO      = 8'h04;

   // Interrupt bit positions and reset
   localparam int         IRQ_W            = 3;
   localparam int         IRQ_ATTACH_CHG   = 0;
   localparam int         IRQ_POWER_CHG    = 1;
   localparam int         IRQ_SUPPLY_FAULT = 2;
   localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

   // Control bits and reset
   localparam int         CTRL_OVLO_CHECK  = 0;
   localparam int         CTRL_RANGE_CHECK = 1;
   localparam logic [1:0] CONTROL_RESET    = 2'h3;

   // Pin status bit positions
   localparam int PIN_POWER_LEVEL  = 0;
   localparam int PIN_ORIENT_LEVEL = 1;
   localparam int PIN_VCONN_CC1    = 2;
   localparam int PIN_VCONN_CC2    = 3;

   function automatic logic isPowered(tcsrc_state_t s);
      return (s == ST_ATTACHED) || (s == ST_DEBUG_UNORIENTED) ||
             (s == ST_DEBUG_ORIENTED);
   endfunction

   function automatic logic [7:0] attachCode(tcsrc_state_t s,
                                             tcsrc_vconn_t v);
      logic [7:0] c;
      c = CODE_NONE;
      case (s)
         ST_ATTACHED:         c = (v == VCONN_OFF) ? CODE_SINK
                                                   : CODE_SINK_VCONN;
         ST_DEBUG_UNORIENTED: c = CODE_DEBUG;
         ST_DEBUG_ORIENTED:   c = CODE_DEBUG;
         ST_AUDIO:            c = CODE_AUDIO;
         default:             c = CODE_NONE;
      endcase
      return c;
   endfunction

   function automatic logic [7:0] portCode(tcsrc_state_t s);
      logic [7:0] c;
      c = PORT_UNATTACHED;
      case (s)
         ST_ATTACHED:         c = PORT_ATTACHED;
         ST_DEBUG_UNORIENTED: c = PORT_DBG_UNOR;
         ST_DEBUG_ORIENTED:   c = PORT_DBG_OR;
         ST_AUDIO:            c = PORT_AUDIO;
         default:             c = PORT_UNATTACHED;
      endcase
      return c;
   endfunction

endpackage

/* hw/tcsrc_top.sv */
// Source attach state, port outputs and register file
//
// Function
// - Enable low only when attached or debug, no overvoltage, bus in range.
// - Release enable as soon as any enabling condition fails.
// - Attach codes 00h none, 2Dh sink, 2Fh with VCONN, 6Dh debug, 81h audio.
// - Orientation low when sink is on CC2, released otherwise.
// - Rd with Ra attaches and powers VCONN on the Ra line only.
// - Ra/Rp only stays unattached; Rd-Rd unoriented debug; Ra-Ra audio.
// - Attach code may show passing values during transitions; ignore them.
// - Rd with below-Ra gives oriented debug, power on, VCONN off.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
module tcsrc_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  logic                    clk_sys,
   input  logic                    reset,
   // Avalon-MM slave
   input  logic [ADDR_W-1:0]       avs_address,
   input  logic                    avs_read,
   input  logic                    avs_write,
   input  logic [31:0]             avs_writedata,
   input  logic [3:0]              avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   // CC line terminations
   input  tcsrc_pkg::tcsrc_term_t  cc1Term,
   input  tcsrc_pkg::tcsrc_term_t  cc2Term,
   // Supply and bus voltage monitors
   input  logic                    supplyPresent,
   input  logic                    supplyOvervoltage,
   input  logic                    busVoltageSenseInput,
   // Open-drain bus power enable
   input  logic                    sourcePowerEnableNIn,
   output logic                    sourcePowerEnableNOut,
   output logic                    sourcePowerEnableNOe,
   // Open-drain orientation flag
   input  logic                    orientFlagNIn,
   output logic                    orientFlagNOut,
   output logic                    orientFlagNOe,
   // VCONN switches
   output logic                    vconnCc1En,
   output logic                    vconnCc2En,
   // Interrupt
   output logic                    irq
);
   tcsrc_pkg::tcsrc_state_t state;
   tcsrc_pkg::tcsrc_state_t next_state;
   tcsrc_pkg::tcsrc_vconn_t next_vconn;
   logic                    next_flip;
   logic [7:0]              attachStatus;
   logic [7:0]              portState;
   logic [1:0]              control;
   logic                    suppliesOk;
   logic                    next_powerOn;
   logic                    busAck;
   logic                    wrAck;
   logic [31:0]             next_readdata;
   logic [tcsrc_pkg::IRQ_W-1:0] events;
   logic [tcsrc_pkg::IRQ_W-1:0] irqStatus;
   logic [tcsrc_pkg::IRQ_W-1:0] irqEnable;
   logic                    irqEnableWr;
   logic                    irqClearWr;

   if (ADDR_W < 5) begin : g_check
      $error("tcsrc_top needs ADDR_W of 5 or more");
   end

   ////////////////////////////////////////////////////////////////////////
   // Attach decode and power conditions

   tcsrc_cc_decode u_decode (
      .cc1Term    (cc1Term),
      .cc2Term    (cc2Term),
      .next_state (next_state),
      .next_flip  (next_flip),
      .next_vconn (next_vconn)
   );

   // A disabled check counts as passed; overvoltage only matters when the
   // high-voltage supply is actually there
   always_comb begin
      suppliesOk = 1'b1;
      if (control[tcsrc_pkg::CTRL_OVLO_CHECK] && supplyPresent &&
          supplyOvervoltage) begin
         suppliesOk = 1'b0;
      end else if (control[tcsrc_pkg::CTRL_RANGE_CHECK] &&
                   !busVoltageSenseInput) begin
         suppliesOk = 1'b0;
      end
      next_powerOn = tcsrc_pkg::isPowered(next_state) && suppliesOk;
   end

   ////////////////////////////////////////////////////////////////////////
   // State and status codes, updated together

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state        <= tcsrc_pkg::ST_UNATTACHED;
         attachStatus <= tcsrc_pkg::CODE_NONE;
         portState    <= tcsrc_pkg::PORT_UNATTACHED;
      end else begin
         state        <= next_state;
         // No staging through other codes here, so passing values that
         // software is told to ignore never actually appear
         attachStatus <=
            tcsrc_pkg::attachCode(next_state, next_vconn);
         portState    <= tcsrc_pkg::portCode(next_state);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port outputs

   // Open-drain pins only ever pull low; the output enable does the work
   always_ff @(posedge clk_sys) begin
      sourcePowerEnableNOut <= 1'b0;
      orientFlagNOut        <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sourcePowerEnableNOe <= 1'b0;
         orientFlagNOe        <= 1'b0;
         vconnCc1En           <= 1'b0;
         vconnCc2En           <= 1'b0;
      end else begin
         sourcePowerEnableNOe <= next_powerOn;
         // Unoriented debug and audio carry no orientation
         orientFlagNOe <= next_flip &&
            (next_state == tcsrc_pkg::ST_ATTACHED ||
             next_state == tcsrc_pkg::ST_DEBUG_ORIENTED);
         vconnCc1En <= (next_state == tcsrc_pkg::ST_ATTACHED) &&
                       (next_vconn == tcsrc_pkg::VCONN_CC1);
         vconnCc2En <= (next_state == tcsrc_pkg::ST_ATTACHED) &&
                       (next_vconn == tcsrc_pkg::VCONN_CC2);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, answer on the second edge

   assign busAck      = (avs_read || avs_write) && !avs_waitrequest;
   assign wrAck       = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign irqEnableWr = wrAck &&
                        (avs_address == ADDR_W'(tcsrc_pkg::REG_IRQ_ENABLE));
   assign irqClearWr  = wrAck &&
                        (avs_address == ADDR_W'(tcsrc_pkg::REG_IRQ_CLEAR));

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_address == ADDR_W'(tcsrc_pkg::REG_ATTACH_STATUS)) begin
         next_readdata[7:0] = attachStatus;
      end else if (avs_address == ADDR_W'(tcsrc_pkg::REG_PORT_STATE)) begin
         next_readdata[7:0] = portState;
      end else if (avs_address == ADDR_W'(tcsrc_pkg::REG_IRQ_STATUS)) begin
         next_readdata[tcsrc_pkg::IRQ_W-1:0] = irqStatus;
      end else if (avs_address == ADDR_W'(tcsrc_pkg::REG_IRQ_ENABLE)) begin
         next_readdata[tcsrc_pkg::IRQ_W-1:0] = irqEnable;
      end else if (avs_address == ADDR_W'(tcsrc_pkg::REG_CONTROL)) begin
         next_readdata[1:0] = control;
      end else if (avs_address == ADDR_W'(tcsrc_pkg::REG_PIN_STATUS)) begin
         next_readdata[tcsrc_pkg::PIN_POWER_LEVEL]  = sourcePowerEnableNIn;
         next_readdata[tcsrc_pkg::PIN_ORIENT_LEVEL] = orientFlagNIn;
         next_readdata[tcsrc_pkg::PIN_VCONN_CC1]    = vconnCc1En;
         next_readdata[tcsrc_pkg::PIN_VCONN_CC2]    = vconnCc2En;
      end
   end

   // Read data loads with the wait release so it stands at the taking edge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         control <= tcsrc_pkg::CONTROL_RESET;
      end else if (wrAck &&
                   avs_address == ADDR_W'(tcsrc_pkg::REG_CONTROL)) begin
         control <= avs_writedata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   always_comb begin
      events = '0;
      events[tcsrc_pkg::IRQ_ATTACH_CHG]   = (next_state != state);
      events[tcsrc_pkg::IRQ_POWER_CHG]    =
         (next_powerOn != sourcePowerEnableNOe);
      events[tcsrc_pkg::IRQ_SUPPLY_FAULT] =
         tcsrc_pkg::isPowered(next_state) && !suppliesOk;
   end

   tcsrc_irq #(.W(tcsrc_pkg::IRQ_W)) u_irq (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .eventIn  (events),
      .enableWr (irqEnableWr),
      .clearWr  (irqClearWr),
      .wrData   (avs_writedata[tcsrc_pkg::IRQ_W-1:0]),
      .status   (irqStatus),
      .enable   (irqEnable),
      .irq      (irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence seqOrientedDebug;
      (cc1Term == tcsrc_pkg::TERM_LOW && cc2Term == tcsrc_pkg::TERM_RD);
   endsequence
   sequence seqUnorientedDebug;
      (cc1Term == tcsrc_pkg::TERM_RD && cc2Term == tcsrc_pkg::TERM_RD);
   endsequence
   sequence seqSuppliesGood;
      !(control[tcsrc_pkg::CTRL_OVLO_CHECK] && supplyPresent &&
        supplyOvervoltage) &&
      (busVoltageSenseInput || !control[tcsrc_pkg::CTRL_RANGE_CHECK]);
   endsequence

   a_enable_on: assert property (
      (tcsrc_pkg::isPowered(next_state) ##0 seqSuppliesGood)
      |=> sourcePowerEnableNOe)
      else $error("power enable not driven when all conditions hold");
   a_enable_off: assert property (
      (!tcsrc_pkg::isPowered(next_state) ||
       (control[tcsrc_pkg::CTRL_OVLO_CHECK] && supplyPresent &&
        supplyOvervoltage) ||
       (control[tcsrc_pkg::CTRL_RANGE_CHECK] && !busVoltageSenseInput))
      |=> !sourcePowerEnableNOe)
      else $error("power enable held after a condition failed");
   a_code_match: assert property (
      (portState == tcsrc_pkg::PORT_ATTACHED) |->
      (attachStatus == ((vconnCc1En || vconnCc2En) ?
                        tcsrc_pkg::CODE_SINK_VCONN : tcsrc_pkg::CODE_SINK)))
      else $error("attach code disagrees with attached state");
   a_orient_side: assert property (
      orientFlagNOe |-> (state == tcsrc_pkg::ST_ATTACHED ||
                         state == tcsrc_pkg::ST_DEBUG_ORIENTED))
      else $error("orientation driven outside an oriented state");
   a_vconn_ra: assert property (
      (cc1Term == tcsrc_pkg::TERM_RD && cc2Term == tcsrc_pkg::TERM_RA)
      |=> vconnCc2En && !vconnCc1En &&
          attachStatus == tcsrc_pkg::CODE_SINK_VCONN)
      else $error("VCONN not on the Ra line");
   a_vconn_off: assert property (
      (state != tcsrc_pkg::ST_ATTACHED) |-> !vconnCc1En && !vconnCc2En)
      else $error("VCONN on outside attached state");
   a_stay_unatt: assert property (
      (cc1Term == tcsrc_pkg::TERM_RP && cc2Term == tcsrc_pkg::TERM_RP)
      |=> !sourcePowerEnableNOe && !orientFlagNOe &&
          attachStatus == tcsrc_pkg::CODE_NONE)
      else $error("Rp pair left the unattached state");
   a_debug_orient: assert property (
      (seqOrientedDebug ##0 seqSuppliesGood) |=>
      (state == tcsrc_pkg::ST_DEBUG_ORIENTED && orientFlagNOe &&
       sourcePowerEnableNOe && !vconnCc1En && !vconnCc2En &&
       attachStatus == tcsrc_pkg::CODE_DEBUG))
      else $error("oriented debug outputs wrong");
   a_state_agree: assert property (
      $changed(state) |-> $changed(portState))
      else $error("port state lagged the state change");
   a_port_code: assert property (
      portState == tcsrc_pkg::portCode(state))
      else $error("port state disagrees with attach state");
   a_debug_unor: assert property (
      (seqUnorientedDebug ##0 seqSuppliesGood) |=>
      (state == tcsrc_pkg::ST_DEBUG_UNORIENTED && sourcePowerEnableNOe &&
       !orientFlagNOe && attachStatus == tcsrc_pkg::CODE_DEBUG))
      else $error("unoriented debug outputs wrong");
   a_audio_quiet: assert property (
      (cc1Term == tcsrc_pkg::TERM_RA && cc2Term == tcsrc_pkg::TERM_RA)
      |=> !sourcePowerEnableNOe && !orientFlagNOe && !vconnCc1En &&
          !vconnCc2En && attachStatus == tcsrc_pkg::CODE_AUDIO)
      else $error("audio adapter drove a port output");
   a_vconn_cc1: assert property (
      (cc1Term == tcsrc_pkg::TERM_RA && cc2Term == tcsrc_pkg::TERM_RD)
      |=> vconnCc1En && !vconnCc2En && orientFlagNOe)
      else $error("VCONN not on CC1 for a flipped cable");
   a_bus_answer: assert property (
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");
   a_bus_single: assert property (busAck |=> avs_waitrequest)
      else $error("wait release lasted more than one cycle");
endmodule // tcsrc_top

/* sim/tcsrc_far_end.sv */
// Far-end model: sink, cable or accessory terminations plus pin pull-ups
`timescale 1ns/10ps
module tcsrc_far_end (
   // Which attachment the far side presents
   input  wire logic [3:0]             presentIdx,
   // Open-drain pins from the block
   input  wire logic                   powerOut,
   input  wire logic                   powerOe,
   input  wire logic                   orientOut,
   input  wire logic                   orientOe,
   // Terminations and resolved pin levels
   output tcsrc_pkg::tcsrc_term_t      cc1Term,
   output tcsrc_pkg::tcsrc_term_t      cc2Term,
   output logic                        powerPinN,
   output logic                        orientPinN
);
   ////////////////////////////////////////////////////////////////////////
   // Attachments in table order; anything past the end is unplugged
   logic [5:0] termPair;
   always_comb begin
      case (presentIdx)
         4'h1:    termPair = {tcsrc_pkg::TERM_RD, tcsrc_pkg::TERM_OPEN};
         4'h2:    termPair = {tcsrc_pkg::TERM_OPEN, tcsrc_pkg::TERM_RD};
         4'h3:    termPair = {tcsrc_pkg::TERM_OPEN, tcsrc_pkg::TERM_RA};
         4'h4:    termPair = {tcsrc_pkg::TERM_RA, tcsrc_pkg::TERM_OPEN};
         4'h5:    termPair = {tcsrc_pkg::TERM_RD, tcsrc_pkg::TERM_RA};
         4'h6:    termPair = {tcsrc_pkg::TERM_RA, tcsrc_pkg::TERM_RD};
         4'h7:    termPair = {tcsrc_pkg::TERM_RP, tcsrc_pkg::TERM_RP};
         4'h8:    termPair = {tcsrc_pkg::TERM_RD, tcsrc_pkg::TERM_RD};
         4'h9:    termPair = {tcsrc_pkg::TERM_RD, tcsrc_pkg::TERM_LOW};
         4'ha:    termPair = {tcsrc_pkg::TERM_LOW, tcsrc_pkg::TERM_RD};
         4'hb:    termPair = {tcsrc_pkg::TERM_RA, tcsrc_pkg::TERM_RA};
         default: termPair = {tcsrc_pkg::TERM_OPEN, tcsrc_pkg::TERM_OPEN};
      endcase
   end
   assign cc1Term = tcsrc_pkg::tcsrc_term_t'(termPair[5:3]);
   assign cc2Term = tcsrc_pkg::tcsrc_term_t'(termPair[2:0]);

   ////////////////////////////////////////////////////////////////////////
   // Board pull-ups: a released pin reads high, never the last driven value
   assign powerPinN  = powerOe ? powerOut : 1'b1;
   assign orientPinN = orientOe ? orientOut : 1'b1;
endmodule // tcsrc_far_end

/* sim/typec_source_attach_outputs_tb.sv */
// Self-checking bench: attach table, power gating, registers, interrupt
`timescale 1ns/10ps
module typec_source_attach_outputs_tb;
   logic                   clk_sys, reset, avs_read, avs_write;
   logic [7:0]             avs_address;
   logic [31:0]            avs_writedata, avs_readdata, rdata;
   logic [3:0]             avs_byteenable, farIdx;
   logic                   avs_waitrequest, supplyPresent, supplyOvervoltage;
   logic                   busVoltageSenseInput, powerPinN, orientPinN;
   logic                   powerOut, powerOe, orientOut, orientOe;
   logic                   vconnCc1En, vconnCc2En, irq;
   tcsrc_pkg::tcsrc_term_t cc1Term, cc2Term;
   int                     n_mismatch, compares;
   // Expected {attach code, port code, vconn1, vconn2, orient, power}
   logic [19:0] expTab [12] = '{20'h00000, 20'h2d011, 20'h2d013, 20'h00000,
      20'h00000, 20'h2f015, 20'h2f01b, 20'h00000, 20'h6d021, 20'h6d031,
      20'h6d033, 20'h81040};

   tcsrc_top u_tcsrc_top (.clk_sys(clk_sys), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cc1Term(cc1Term), .cc2Term(cc2Term), .supplyPresent(supplyPresent),
      .supplyOvervoltage(supplyOvervoltage),
      .busVoltageSenseInput(busVoltageSenseInput),
      .sourcePowerEnableNIn(powerPinN), .sourcePowerEnableNOut(powerOut),
      .sourcePowerEnableNOe(powerOe), .orientFlagNIn(orientPinN),
      .orientFlagNOut(orientOut), .orientFlagNOe(orientOe),
      .vconnCc1En(vconnCc1En), .vconnCc2En(vconnCc2En), .irq(irq));

   tcsrc_far_end u_tcsrc_far_end (.presentIdx(farIdx), .powerOut(powerOut),
      .powerOe(powerOe), .orientOut(orientOut), .orientOe(orientOe),
      .cc1Term(cc1Term), .cc2Term(cc2Term), .powerPinN(powerPinN),
      .orientPinN(orientPinN));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdata = avs_readdata;
      if (n >= 50) check("bus answer", 32'h1, 32'h0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      check(what, rdata, exp);
   endtask

   // Input change lands at the next edge; sample once it has settled
   task automatic settle();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic give_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [19:0] e;
      n_mismatch = 0;
      compares = 0;
      reset = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      farIdx = 4'h0;
      supplyPresent = 1'b1;
      supplyOvervoltage = 1'b0;
      busVoltageSenseInput = 1'b1;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      rd_chk("irq enable reset", tcsrc_pkg::REG_IRQ_ENABLE, 32'h0);
      rd_chk("control reset", tcsrc_pkg::REG_CONTROL, 32'h3);
      rd_chk("unmapped", 8'h30, 32'h0);
      // Every attachment of the table, each through its registers and pins
      for (int i = 0; i < 12; i++) begin
         e = expTab[i];
         @(posedge clk_sys);
         farIdx <= i[3:0];
         settle();
         check("vconn cc1", vconnCc1En, e[3]);
         check("vconn cc2", vconnCc2En, e[2]);
         check("orient oe", orientOe, e[1]);
         check("power oe", powerOe, e[0]);
         check("power out", powerOut, 1'b0);
         check("orient out", orientOut, 1'b0);
         rd_chk("attach code", tcsrc_pkg::REG_ATTACH_STATUS, e[19:12]);
         rd_chk("port state", tcsrc_pkg::REG_PORT_STATE, e[11:4]);
         rd_chk("pins", tcsrc_pkg::REG_PIN_STATUS,
                {28'h0, e[2], e[3], ~e[1], ~e[0]});
      end
      // Each enabling condition failing alone releases the enable
      @(posedge clk_sys);
      farIdx <= 4'h1;
      supplyOvervoltage <= 1'b1;
      settle();
      check("power oe ovlo", powerOe, 1'b0);
      @(posedge clk_sys);
      supplyOvervoltage <= 1'b0;
      busVoltageSenseInput <= 1'b0;
      settle();
      check("power oe range", powerOe, 1'b0);
      @(posedge clk_sys);
      busVoltageSenseInput <= 1'b1;
      settle();
      check("power oe back", powerOe, 1'b1);
      @(posedge clk_sys);
      supplyPresent <= 1'b0;
      supplyOvervoltage <= 1'b1;
      settle();
      check("ovlo unsupplied", powerOe, 1'b1);
      bus(1'b1, tcsrc_pkg::REG_CONTROL, 32'h2, 4'hf);
      supplyPresent <= 1'b1;
      settle();
      check("ovlo check off", powerOe, 1'b1);
      bus(1'b1, tcsrc_pkg::REG_CONTROL, 32'h3, 4'hf);
      settle();
      check("ovlo check on", powerOe, 1'b0);
      rd_chk("irq status all", tcsrc_pkg::REG_IRQ_STATUS, 32'h7);
      supplyOvervoltage <= 1'b0;
      // Interrupt: set, masked, enabled, cleared; ignored writes
      bus(1'b1, tcsrc_pkg::REG_IRQ_CLEAR, 32'h7, 4'hf);
      rd_chk("irq status clear", tcsrc_pkg::REG_IRQ_STATUS, 32'h0);
      @(posedge clk_sys);
      farIdx <= 4'h0;
      settle();
      rd_chk("irq status set", tcsrc_pkg::REG_IRQ_STATUS, 32'h3);
      check("irq masked", irq, 1'b0);
      bus(1'b1, tcsrc_pkg::REG_IRQ_ENABLE, 32'h1, 4'h0);
      rd_chk("enable be0", tcsrc_pkg::REG_IRQ_ENABLE, 32'h0);
      bus(1'b1, tcsrc_pkg::REG_IRQ_ENABLE, 32'h1, 4'hf);
      repeat (2) settle();
      check("irq on", irq, 1'b1);
      bus(1'b1, tcsrc_pkg::REG_IRQ_CLEAR, 32'h1, 4'hf);
      repeat (2) settle();
      check("irq off", irq, 1'b0);
      rd_chk("irq status left", tcsrc_pkg::REG_IRQ_STATUS, 32'h2);
      bus(1'b1, tcsrc_pkg::REG_ATTACH_STATUS, 32'h55, 4'hf);
      rd_chk("ro write", tcsrc_pkg::REG_ATTACH_STATUS, 32'h0);
      give_verdict();
   end
endmodule // typec_source_attach_outputs_tb
